// File: adc_conversion_and_output_port.sv
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "adc_port_consts.svh"
// Summary of operation
// - started conversion never restarts nor aborts, even powered-down
// - convert strobe works regardless of select and read
// - impulse mode: strobe held low self-retriggers after acquisition
// - self-retrigger loop may exceed guaranteed impulse rate
// - warp and normal modes need explicit strobe
// - select OR read high tristates interface outputs
// - serial select low parallel, high serial
// - byte order select swaps result bytes on the parallel bus
// - serial sends 16 bits MSB first
// - internal clock mode drives clock and frame strobe
// - master clock and frame strobe may be inverted
// - read-timing input picks after or during conversion
// - master read-after keeps busy through 16 bits
// - external clock gated by select, read when selected
// - external clock continuous or gapped, either idle level
// - host reads after busy falls, below 10 MHz (half the hclk rate)
// - daisy chain only in slave read-after mode
// - chain bit latched on opposite edge, follows lsb
// - output coding select picks two's complement or binary
// - unfinished slave read at conversion end pulses overrun
module adc_conversion_and_output_port (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic convert_strobe_n,
    input wire logic power_down_input,
    input wire logic chip_select_n,
    input wire logic read_strobe_n,
    input wire logic serial_parallel_select,
    input wire logic byte_order_select,
    input wire logic clock_source_select,
    input wire logic read_timing_chain_input,
    input wire logic output_coding_select,
    input wire logic serial_clock_in,
    input wire logic [15:0] sar_code,
    output logic busy,
    output logic [15:0] data_bus_out,
    output logic data_bus_oe_n,
    output logic serial_data_out,
    output logic serial_clock_out,
    output logic frame_sync_out,
    output logic serial_oe_n,
    output logic read_overrun_flag
);

    adc_port_pkg::pins_s pins_raw;
    adc_port_pkg::pins_s pins_meta;
    adc_port_pkg::pins_s pins;
    adc_port_pkg::ctrl_s ctrl;
    adc_port_pkg::ahb_req_s req;
    adc_port_pkg::conv_state_e state;
    logic cnv_prev;
    logic cnv_fall;
    logic [5:0] cnt;
    logic eoc;
    logic acq_end;
    logic conv_start;
    logic impulse;
    logic sel;
    logic sel_prev;
    logic master;
    logic slave;
    logic [15:0] result;
    logic [15:0] coded_new;
    logic [15:0] coded_result;
    logic [15:0] shift_reg;
    logic mtx_active;
    logic [4:0] mtx_cnt;
    logic mtx_done;
    logic sclk_prev;
    logic sclk_idle;
    logic sclk_leave;
    logic sclk_return;
    logic chain_bit;
    logic [4:0] slave_cnt;
    adc_port_pkg::conv_state_e next_after;

    // pin inputs gathered for the two-flop synchroniser
    assign pins_raw = '{cnv_n: convert_strobe_n, pd: power_down_input,
                        cs_n: chip_select_n, rd_n: read_strobe_n,
                        ser: serial_parallel_select,
                        swap: byte_order_select,
                        ext: clock_source_select,
                        rdc: read_timing_chain_input,
                        coding: output_coding_select,
                        sclk: serial_clock_in};

    // synchroniser, plus edge history that reads only the second stage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pins_meta <= `PINS_RESET;
            pins <= `PINS_RESET;
            cnv_prev <= 1'b1;
            sclk_prev <= 1'b0;
            sel_prev <= 1'b0;
        end else begin
            pins_meta <= pins_raw;
            pins <= pins_meta;
            cnv_prev <= pins.cnv_n;
            sclk_prev <= pins.sclk;
            sel_prev <= sel;
        end
    end

    // decoded interface modes
    assign sel = !pins.cs_n && !pins.rd_n;
    assign master = pins.ser && !pins.ext;
    assign slave = pins.ser && pins.ext;
    assign impulse = (ctrl.mode == adc_port_pkg::MODE_IMPULSE);
    assign cnv_fall = cnv_prev && !pins.cnv_n;

    // result coding: flip the msb for two's complement
    function automatic logic [15:0] code_of(input logic [15:0] v,
                                            input logic binary);
        code_of = binary ? v : {~v[15], v[14:0]};
    endfunction : code_of

    assign coded_new = code_of(sar_code, pins.coding);
    assign coded_result = code_of(result, pins.coding);

    // sequencer timing events
    assign eoc = (state == adc_port_pkg::ST_CONVERT) &&
                 (cnt == 6'(`CONV_CYCLES - 1));
    assign acq_end = (state == adc_port_pkg::ST_ACQUIRE) &&
                     (cnt == 6'(`ACQ_CYCLES - 1));
    assign conv_start = ((state == adc_port_pkg::ST_IDLE) && cnv_fall &&
                         !pins.pd) || (acq_end && !pins.pd);
    assign next_after = (impulse && !pins.cnv_n) ?
                        adc_port_pkg::ST_ACQUIRE : adc_port_pkg::ST_IDLE;
    assign mtx_done = mtx_active && (mtx_cnt == `MSEND_LAST);

    // conversion sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= adc_port_pkg::ST_IDLE;
            cnt <= 6'h00;
        end else begin
            case (state)
                adc_port_pkg::ST_IDLE: begin
                    cnt <= 6'h00;
                    if (conv_start) begin
                        state <= adc_port_pkg::ST_CONVERT;
                    end else if (impulse && !pins.cnv_n && !pins.pd) begin
                        state <= adc_port_pkg::ST_ACQUIRE;
                    end
                end
                adc_port_pkg::ST_CONVERT: begin
                    // power-down is not looked at here; the strobe only picks the state after eoc
                    cnt <= cnt + 6'h01;
                    if (eoc) begin
                        cnt <= 6'h00;
                        if (master && !pins.rdc) begin
                            state <= adc_port_pkg::ST_MSEND;
                        end else begin
                            state <= next_after;
                        end
                    end
                end
                adc_port_pkg::ST_ACQUIRE: begin
                    // self-timed acquisition, shorter than a strobe period
                    cnt <= cnt + 6'h01;
                    if (acq_end) begin
                        cnt <= 6'h00;
                        state <= pins.pd ? adc_port_pkg::ST_IDLE :
                                 adc_port_pkg::ST_CONVERT;
                    end
                end
                adc_port_pkg::ST_MSEND: begin
                    cnt <= 6'h00;
                    if (mtx_done) begin
                        state <= next_after;
                    end
                end
                default: begin
                    state <= adc_port_pkg::ST_IDLE;
                    cnt <= 6'h00;
                end
            endcase
        end
    end

    // busy covers conversion and the extended master send
    assign busy = (state == adc_port_pkg::ST_CONVERT) ||
                  (state == adc_port_pkg::ST_MSEND);

    // result latch at end of conversion
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result <= 16'h0000;
        end else if (eoc) begin
            result <= sar_code;
        end
    end

    // parallel bus data, with byte order select
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_bus_out <= 16'h0000;
        end else if (pins.swap) begin
            data_bus_out <= {coded_result[7:0], coded_result[15:8]};
        end else begin
            data_bus_out <= coded_result;
        end
    end

    // output enables (low while driving)
    assign data_bus_oe_n = !(sel && !pins.ser);
    assign serial_oe_n = !(sel && pins.ser);

    // master send counter: two hclk cycles per bit, 16 bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mtx_active <= 1'b0;
            mtx_cnt <= 5'h00;
        end else if ((eoc && master && !pins.rdc) ||
                     (conv_start && master && pins.rdc)) begin
            mtx_active <= 1'b1;
            mtx_cnt <= 5'h00;
        end else if (mtx_done) begin
            mtx_active <= 1'b0;
            mtx_cnt <= 5'h00;
        end else if (mtx_active) begin
            mtx_cnt <= mtx_cnt + 5'h01;
        end
    end

    // master clock high in the second half of each bit, then invert
    assign serial_clock_out = (mtx_active & mtx_cnt[0]) ^
                              ctrl.inv_sclk;
    assign frame_sync_out = mtx_active ^ ctrl.inv_sync;
    assign serial_data_out = shift_reg[15];

    // slave clock pulses: leaving the idle level, then returning to it
    assign sclk_leave = slave && sel && (pins.sclk != sclk_prev) &&
                        (sclk_prev == sclk_idle);
    assign sclk_return = slave && sel && (pins.sclk != sclk_prev) &&
                         (sclk_prev != sclk_idle);

    // idle level of the host clock, taken when the read window opens
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sclk_idle <= 1'b0;
        end else if (sel && !sel_prev) begin
            sclk_idle <= pins.sclk;
        end
    end

    // chain bit caught on the edge opposite the shifting edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chain_bit <= 1'b0;
        end else if (sclk_leave) begin
            chain_bit <= !busy && pins.rdc;
        end
    end

    // output shifter shared by master and slave modes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_reg <= 16'h0000;
        end else if (eoc && (slave || (master && !pins.rdc))) begin
            shift_reg <= coded_new;
        end else if (conv_start && master && pins.rdc) begin
            shift_reg <= coded_result;
        end else if (mtx_active && mtx_cnt[0]) begin
            shift_reg <= {shift_reg[14:0], 1'b0};
        end else if (sclk_return) begin
            shift_reg <= {shift_reg[14:0], chain_bit};
        end
    end

    // slave bit count and read overrun pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slave_cnt <= 5'h00;
            read_overrun_flag <= 1'b0;
        end else begin
            read_overrun_flag <= eoc && slave && (slave_cnt != 5'h00) &&
                                 (slave_cnt < 5'h10);
            if (eoc) begin
                slave_cnt <= 5'h00;
            end else if (sclk_return && (slave_cnt < 5'h10)) begin
                slave_cnt <= slave_cnt + 5'h01;
            end
        end
    end

    // ahb-lite slave: zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // address phase capture and registered read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req <= '0;
            hrdata <= 32'h00000000;
        end else if (hready) begin
            req.valid <= hsel && htrans[1];
            req.write <= hwrite;
            req.addr <= haddr[7:0];
            hrdata <= 32'h00000000;
            if (hsel && htrans[1] && !hwrite) begin
                case (haddr[7:0])
                    `CTRL_OFFSET: hrdata <= {28'h0000000, ctrl};
                    `STATUS_OFFSET: hrdata <= {21'h000000, slave_cnt,
                        pins.ext, pins.ser, state, mtx_active, busy};
                    `RESULT_OFFSET: hrdata <= {16'h0000, result};
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    // control register write in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= `CTRL_RESET;
        end else if (req.valid && req.write &&
                     (req.addr == `CTRL_OFFSET)) begin
            ctrl <= hwdata[3:0];
        end
    end

    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_conv_no_abort: assert property (
        (state == adc_port_pkg::ST_CONVERT) && !eoc
        |=> (state == adc_port_pkg::ST_CONVERT))
        else $error("conversion left before its end");
    a_conv_length: assert property (
        $rose(busy) |-> busy[*8] ##26 eoc)
        else $error("conversion length wrong");
    a_strobe_starts: assert property (
        (state == adc_port_pkg::ST_IDLE) && cnv_fall && !pins.pd
        |=> busy)
        else $error("strobe edge did not start conversion");
    a_impulse_loop: assert property (
        acq_end && !pins.pd |=> (state == adc_port_pkg::ST_CONVERT))
        else $error("impulse loop did not retrigger");
    a_no_auto_mode: assert property (
        (state == adc_port_pkg::ST_ACQUIRE) |-> impulse)
        else $error("self retrigger outside impulse mode");
    a_bus_tristate: assert property (
        (chip_select_n || read_strobe_n)[*3] |-> data_bus_oe_n && serial_oe_n)
        else $error("outputs driven while deselected");
    a_port_select: assert property (
        !data_bus_oe_n |-> !pins.ser)
        else $error("parallel bus driven in serial mode");
    a_master_bits: assert property (
        $rose(mtx_active) |-> ##31 mtx_active ##1
        (!mtx_active || $past(mtx_done)))
        else $error("master send not 16 bits");
    a_busy_extend: assert property (
        eoc && master && !pins.rdc |=> busy[*8])
        else $error("busy dropped before master send");
    a_overrun_pulse: assert property (
        read_overrun_flag |-> $past(eoc) ##1 !read_overrun_flag)
        else $error("overrun flag not a single pulse after conversion");
    a_coding_msb: assert property (
        !pins.coding && !pins.swap |=> data_bus_out[15] != $past(result[15]))
        else $error("two's complement coding wrong");

    c_impulse_loop: cover property (acq_end ##1 busy);
    c_master_after: cover property (eoc && master && !pins.rdc);
    c_slave_overrun: cover property (read_overrun_flag);
    c_parallel_read: cover property (!data_bus_oe_n && pins.swap);

endmodule : adc_conversion_and_output_port

// File: adc_conversion_and_output_port_bench.sv
`timescale 1ns/1ps
module adc_conversion_and_output_port_bench;
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, busy, data_bus_oe_n, serial_data_out;
    logic serial_clock_out, frame_sync_out, serial_oe_n, read_overrun_flag;
    logic convert_strobe_n, serial_clock_in, power_down_input = 1'h0;
    logic chip_select_n = 1'h1, read_strobe_n = 1'h1;
    logic serial_parallel_select = 1'h0, byte_order_select = 1'h0;
    logic clock_source_select = 1'h0, read_timing_chain_input = 1'h0;
    logic output_coding_select = 1'h1;
    logic [15:0] sar_code = 16'h0000, data_bus_out, v, c, prev, cur;
    logic [31:0] seed = 32'h0001796E;
    int n_fail = 0, checked = 0, len, ovr = 0;
    bit ok;

    adc_conversion_and_output_port u_dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .convert_strobe_n,
        .power_down_input, .chip_select_n, .read_strobe_n,
        .serial_parallel_select, .byte_order_select, .clock_source_select,
        .read_timing_chain_input, .output_coding_select, .serial_clock_in,
        .sar_code, .busy, .data_bus_out, .data_bus_oe_n, .serial_data_out,
        .serial_clock_out, .frame_sync_out, .serial_oe_n, .read_overrun_flag
    );
    adc_host_model u_host (
        .hclk, .serial_data_out, .serial_oe_n, .convert_strobe_n,
        .serial_clock_in
    );

    // clock and overrun pulse counter
    always #25 hclk = ~hclk;
    always @(posedge hclk) if (read_overrun_flag === 1'h1) ovr++;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // coded result, then byte lanes
    function automatic logic [15:0] exp_code(input logic [15:0] x,
        input logic bin, input logic swap);
        logic [15:0] y;
        y = bin ? x : {~x[15], x[14:0]};
        return swap ? {y[7:0], y[15:8]} : y;
    endfunction : exp_code

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task give_verdict;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    task done(input string s);
        $display("%s done: checked=%0d n_fail=%0d", s, checked, n_fail);
    endtask : done
    // single ahb-lite transfer, address phase then data phase
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge hclk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h000000, a};
        do @(posedge hclk); while (hreadyout !== 1'h1 && ++n < 50);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1 && ++n < 50);
        q = hrdata;
        if (n >= 50) abort_run();
    endtask : ahb
    task wt(input logic lvl, input int lim, output bit hit);
        hit = 0;
        for (int i = 0; i < lim && !hit; i++) begin
            @(posedge hclk);
            #1;
            hit = (busy === lvl);
        end
    endtask : wt
    task must(input logic lvl);
        wt(lvl, 300, ok);
        if (!ok) abort_run();
    endtask : must
    task abort_run;
        n_fail++;
        give_verdict();
    endtask : abort_run
    // one strobed conversion, returns cycles with busy high
    task run(output int n);
        fork
            u_host.strobe(0);
        join_none
        must(1'h1);
        n = 0;
        while (busy === 1'h1 && n < 300) begin
            @(posedge hclk);
            #1;
            n++;
        end
        if (n >= 300) abort_run();
    endtask : run
    // collect 16 master bits as the clock turns active
    task grab(input logic inv, output logic [15:0] w);
        logic was;
        int i, n;
        was = 1'h0;
        i = 0;
        n = 0;
        while (i < 16 && n < 400) begin
            @(posedge hclk);
            #1;
            n++;
            if ((serial_clock_out ^ inv) && !was) begin
                w = {w[14:0], serial_data_out};
                i++;
                check(frame_sync_out ^ inv, 1'h1);
            end
            was = serial_clock_out ^ inv;
        end
        if (i < 16) abort_run();
    endtask : grab

    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'h1;
        ahb(0, 8'h00, 0, r);
        check(r, 32'h00000000);
        check({hreadyout, hresp}, 2'h2);
        ahb(0, 8'h04, 0, r);
        check(r, 32'h00000000);
        ahb(1, 8'h00, 32'h0000000F, r);
        ahb(0, 8'h00, 0, r);
        check(r, 32'h0000000F);
        ahb(1, 8'h10, 32'hFFFFFFFF, r);
        ahb(0, 8'h10, 0, r);
        check(r, 32'h00000000);
        ahb(1, 8'h00, 0, r);
        done("registers");
        // parallel: random codes, coding and byte order, corners first
        for (int k = 0; k < 8; k++) begin
            seed = lfsr(seed);
            c = (k == 0) ? 16'h8000 : (k == 1) ? 16'hFFFF : seed[15:0];
            @(posedge hclk);
            sar_code <= c;
            output_coding_select <= seed[16];
            byte_order_select <= seed[17];
            chip_select_n <= seed[18];
            read_strobe_n <= 1'h1;
            run(len);
            check(len, 34);
            @(posedge hclk);
            chip_select_n <= 1'h0;
            repeat (6) @(posedge hclk);
            #1 check(data_bus_oe_n, 1'h1);
            @(posedge hclk);
            read_strobe_n <= 1'h0;
            repeat (6) @(posedge hclk);
            #1 check(data_bus_oe_n, 1'h0);
            check(data_bus_out, exp_code(c, seed[16], seed[17]));
            ahb(0, 8'h08, 0, r);
            check(r, {16'h0000, c});
        end
        done("parallel");
        // power-down and a second strobe during a conversion
        fork
            run(len);
            begin
                repeat (8) @(posedge hclk);
                power_down_input <= 1'h1;
                u_host.strobe(0);
            end
        join
        check(len, 34);
        @(posedge hclk);
        power_down_input <= 1'h0;
        // strobe held low: only impulse mode retriggers
        for (int m = 0; m < 3; m++) begin
            ahb(1, 8'h00, m, r);
            u_host.strobe(1);
            must(1'h1);
            must(1'h0);
            wt(1'h1, 20, ok);
            check(ok, m == 2);
            u_host.release_strobe();
            must(1'h0);
        end
        done("conversion");
        // master serial, after and during, plain and inverted
        @(posedge hclk);
        serial_parallel_select <= 1'h1;
        output_coding_select <= 1'h1;
        cur = 16'h0000;
        for (int p = 0; p < 4; p++) begin
            ahb(1, 8'h00, p[1] ? 32'h0000000C : 32'h00000000, r);
            seed = lfsr(seed);
            prev = cur;
            cur = seed[15:0];
            @(posedge hclk);
            read_timing_chain_input <= p[0];
            sar_code <= cur;
            repeat (5) @(posedge hclk);
            #1 check(serial_clock_out, p[1]);
            check(frame_sync_out, p[1]);
            fork
                run(len);
                grab(p[1], v);
            join
            check(len, p[0] ? 34 : 66);
            check(v, p[0] ? prev : cur);
        end
        ahb(1, 8'h00, 0, r);
        done("master serial");
        // slave serial read after conversion, chain input high
        @(posedge hclk);
        clock_source_select <= 1'h1;
        read_timing_chain_input <= 1'h1;
        ovr = 0;
        for (int p = 0; p < 2; p++) begin
            @(posedge hclk);
            chip_select_n <= 1'h1;
            u_host.idle_at(p[0]);
            seed = lfsr(seed);
            sar_code <= seed[15:0];
            output_coding_select <= seed[16];
            run(len);
            @(posedge hclk);
            chip_select_n <= 1'h0;
            repeat (5) @(posedge hclk);
            #1 check(serial_oe_n, 1'h0);
            u_host.read(17, p[0], r);
            v = exp_code(seed[15:0], seed[16], 1'h0);
            check(r[16:0], {v, 1'h1});
        end
        repeat (4) @(posedge hclk);
        check(ovr, 0);
        // fresh conversion, partial read, then the next conversion ends it
        run(len);
        u_host.read(5, 1'h1, r);
        ahb(0, 8'h04, 0, r);
        check(r, 32'h00000170);
        run(len);
        repeat (4) @(posedge hclk);
        check(ovr, 1);
        done("slave serial");
        give_verdict();
    end
endmodule : adc_conversion_and_output_port_bench

// File: adc_host_model.sv
`timescale 1ns/1ps
module adc_host_model (
    input wire logic hclk,
    input wire logic serial_data_out,
    input wire logic serial_oe_n,
    output logic convert_strobe_n,
    output logic serial_clock_in
);
    logic last = 1'h0;
    initial convert_strobe_n = 1'h1;
    initial serial_clock_in = 1'h0;
    // strobe low for a few cycles, or left low for self-retriggering
    task strobe(input bit keep);
        @(posedge hclk);
        convert_strobe_n <= 1'h0;
        if (!keep) begin
            repeat (4) @(posedge hclk);
            convert_strobe_n <= 1'h1;
        end
    endtask : strobe
    task release_strobe;
        @(posedge hclk);
        convert_strobe_n <= 1'h1;
    endtask : release_strobe
    // idle level is set while the device is still deselected
    task idle_at(input logic lvl);
        serial_clock_in <= lvl;
    endtask : idle_at
    // 200 ns pulses every 400 ns, busy is not looked at; bit taken as clock leaves idle
    task read(input int n, input logic lvl, output logic [31:0] w);
        w = '0;
        repeat (4) @(posedge hclk);
        for (int i = 0; i < n; i++) begin
            last = serial_oe_n ? ~last : serial_data_out; // released line
            w = {w[30:0], last};
            serial_clock_in <= ~lvl;
            repeat (4) @(posedge hclk);
            serial_clock_in <= lvl;
            repeat (4) @(posedge hclk);
        end
    endtask : read
endmodule : adc_host_model

// File: adc_port_consts.svh
`ifndef ADC_PORT_CONSTS_SVH
`define ADC_PORT_CONSTS_SVH

// register byte offsets on the ahb-lite slave
`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define RESULT_OFFSET 8'h08
`define REG_ADDR_BITS 8

// control register fields and reset value
`define CTRL_MODE_LSB 0
`define CTRL_INV_SCLK_BIT 2
`define CTRL_INV_SYNC_BIT 3
`define CTRL_RESET 4'h0

// reset level of the synchronised pins (strobes idle high)
`define PINS_RESET 10'h2C0

// result width and timing
`define RESULT_BITS 16
`define HCLK_PERIOD_NS 50
`define CONV_TIME_NS 1700
`define ACQ_TIME_NS 250
`define CONV_CYCLES ((`CONV_TIME_NS + `HCLK_PERIOD_NS - 1) / `HCLK_PERIOD_NS)
`define ACQ_CYCLES ((`ACQ_TIME_NS + `HCLK_PERIOD_NS - 1) / `HCLK_PERIOD_NS)
`define MSEND_LAST 5'h1F

`endif

// File: adc_port_pkg.sv
package adc_port_pkg;

    // conversion sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONVERT,
        ST_ACQUIRE,
        ST_MSEND
    } conv_state_e;

    // conversion modes held in the control register
    typedef enum logic [1:0] {
        MODE_WARP,
        MODE_NORMAL,
        MODE_IMPULSE
    } conv_mode_e;

    // pin-side inputs, carried together through the synchroniser
    typedef struct packed {
        logic cnv_n;
        logic pd;
        logic cs_n;
        logic rd_n;
        logic ser;
        logic swap;
        logic ext;
        logic rdc;
        logic coding;
        logic sclk;
    } pins_s;

    // software control fields
    typedef struct packed {
        logic inv_sync;
        logic inv_sclk;
        conv_mode_e mode;
    } ctrl_s;

    // captured ahb address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } ahb_req_s;

endpackage : adc_port_pkg
